/* File: hw/adcc_pkg.sv */
// Constants for the ADC conversion control block.
// Assumes AXI4-Lite register access with 32-bit data.
package adcc_pkg;

    // Printed offsets are not multiples of four: they are indices, byte address = 4 * index
    localparam logic [11:0] ADCC_IDX_CTL0    = 12'hf70;
    localparam logic [11:0] ADCC_IDX_CTL1    = 12'hf71;
    localparam logic [11:0] ADCC_IDX_RES_HI  = 12'hf72;
    localparam logic [11:0] ADCC_IDX_RES_LO  = 12'hf73;
    localparam logic [11:0] ADCC_IDX_IRQ_ST  = 12'hf74;
    localparam logic [11:0] ADCC_IDX_IRQ_MSK = 12'hf75;
    localparam logic [11:0] ADCC_IDX_TRIM0   = 12'hf76;
    localparam logic [11:0] ADCC_IDX_TRIM1   = 12'hf77;
    localparam logic [11:0] ADCC_IDX_TRIM2   = 12'hf78;
    localparam int          ADCC_ADDR_W      = 14;

    localparam logic [7:0]  ADCC_CTL0_RST    = 8'h00;
    localparam logic [7:0]  ADCC_CTL1_RST    = 8'h80;
    localparam int          ADCC_GO_BIT      = 7;
    localparam int          ADCC_REFLO_BIT   = 6;
    localparam int          ADCC_REFOUT_BIT  = 5;
    localparam int          ADCC_REPEAT_BIT  = 4;
    localparam int          ADCC_REFHI_BIT   = 7;

    localparam logic [1:0]  ADCC_REF_EXT     = 2'h0;
    localparam logic [1:0]  ADCC_REF_1V0     = 2'h1;
    localparam logic [1:0]  ADCC_REF_2V0     = 2'h2;

    // Times as figures in ns, cycle counts derived from the 20 ns clock
    localparam int          ADCC_CLK_NS      = 20;
    localparam int          ADCC_CONV_NS     = 102580;
    localparam int          ADCC_REPEAT_NS   = 5120;
    localparam int          ADCC_IDLE_NS     = 3200;
    localparam int          ADCC_PWRUP_NS    = 800;
    localparam int          ADCC_CONV_CYC    = (ADCC_CONV_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS;
    localparam int          ADCC_REPEAT_CYC  = (ADCC_REPEAT_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS;
    localparam int          ADCC_IDLE_CYC    = (ADCC_IDLE_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS;
    localparam int          ADCC_PWRUP_CYC   = (ADCC_PWRUP_NS + ADCC_CLK_NS - 1) / ADCC_CLK_NS;

    localparam logic [1:0]  ADCC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  ADCC_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ADCC_OFF   = 4'h1,
        ADCC_PWRUP = 4'h2,
        ADCC_CONV  = 4'h4,
        ADCC_IDLE  = 4'h8
    } adcc_state_e;

endpackage : adcc_pkg

/* File: hw/adcc_chan_decode.sv */
// Channel select decode to one-hot input switch enables.
// Assumes the analog mux closes switch n while its enable bit is high.
`timescale 1ns/10ps
`default_nettype none
module adcc_chan_decode
    import adcc_pkg::*;
#(
    parameter int N_IN = 8
) (
    input  wire logic [3:0]      code,
    output logic      [N_IN-1:0] switch_en
);
    always_comb begin
        switch_en = '0;
        if (code[3] == 1'b0) begin
            switch_en[code[2:0]] = 1'b1;
        end
        // Codes 8..15 leave every switch open against leakage
    end
endmodule : adcc_chan_decode
`default_nettype wire

/* File: hw/adcc_top.sv */
// ADC conversion control: registers over AXI4-Lite, conversion timing, power-down.
// Assumes an analog core that delivers a 13-bit raw sample on conv_sample.
`timescale 1ns/10ps
`default_nettype none
module adcc_top
    import adcc_pkg::*;
#(
    parameter int          N_IN     = 8,
    parameter int          CONV_CYC = ADCC_CONV_CYC,
    parameter logic [71:0] TRIM     = 72'h0
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADCC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADCC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [12:0]            conv_sample,
    input  wire logic                   conv_overflow,
    output logic [N_IN-1:0]             input_channel_sel,
    output logic [1:0]                  ref_level,
    output logic                        ref_out_buffer,
    output logic                        conv_power_on,
    output logic                        conv_run,
    output logic                        irq
);
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic [7:0]        ctl0;
        logic [7:0]        ctl1;
        logic [12:0]       res;
        logic              ovf;
        logic [4:0]        lo_latch;
        logic              irq_st;
        logic              irq_msk;
        adcc_state_e       st;
        logic [12:0]       cnt;
        logic              first_done;
        logic [N_IN-1:0]   sw;
        logic [1:0]        refl;
        logic              refout;
        logic              pwr;
        logic              irq;
    } adcc_regs_s;

    adcc_regs_s r_r;
    adcc_regs_s r_nxt;
    logic [N_IN-1:0] sw_dec;

    adcc_chan_decode #(.N_IN(N_IN)) u_dec (
        .code      (r_r.ctl0[3:0]),
        .switch_en (sw_dec)
    );

    function automatic logic [11:0] adcc_index(input logic [ADCC_ADDR_W-1:0] a);
        adcc_index = a[ADCC_ADDR_W-1:2];
    endfunction : adcc_index

    localparam logic [12:0] CONV_LAST   = 13'(CONV_CYC - 1);
    localparam logic [12:0] REPEAT_LAST = 13'(ADCC_REPEAT_CYC - 1);
    localparam logic [12:0] IDLE_LAST   = 13'(ADCC_IDLE_CYC - 1);
    localparam logic [12:0] PWRUP_LAST  = 13'(ADCC_PWRUP_CYC - 1);

    logic        wr_go;
    logic        done;
    logic        hi_read;
    logic [11:0] widx;
    logic [11:0] ridx;
    logic [7:0]  wbyte;

    always_comb begin
        r_nxt   = r_r;
        widx    = adcc_index(s_axi_awaddr);
        ridx    = adcc_index(s_axi_araddr);
        wbyte   = s_axi_wdata[7:0];
        wr_go   = 1'b0;
        done    = 1'b0;
        hi_read = 1'b0;

        // Write channel: both address and data taken in the same cycle
        r_nxt.awready = 1'b0;
        r_nxt.wready  = 1'b0;
        if (s_axi_bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_wvalid && !r_r.awready && !r_r.bvalid) begin
            r_nxt.awready = 1'b1;
            r_nxt.wready  = 1'b1;
        end
        if (r_r.awready) begin
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp  = ADCC_RESP_OKAY;
            case (widx)
                ADCC_IDX_CTL0: begin
                    if (s_axi_wstrb[0]) begin
                        // Go bit kept by hardware; a written 0 is ignored
                        r_nxt.ctl0[6:0] = wbyte[6:0];
                        wr_go = wbyte[ADCC_GO_BIT];
                    end
                end
                ADCC_IDX_CTL1: begin
                    if (s_axi_wstrb[0]) begin
                        r_nxt.ctl1 = wbyte;
                    end
                end
                ADCC_IDX_IRQ_ST: begin
                    if (s_axi_wstrb[0] && wbyte[0]) begin
                        r_nxt.irq_st = 1'b0;
                    end
                end
                ADCC_IDX_IRQ_MSK: begin
                    if (s_axi_wstrb[0]) begin
                        r_nxt.irq_msk = wbyte[0];
                    end
                end
                ADCC_IDX_RES_HI, ADCC_IDX_RES_LO, ADCC_IDX_TRIM0, ADCC_IDX_TRIM1, ADCC_IDX_TRIM2: begin
                    r_nxt.bresp = ADCC_RESP_OKAY;
                end
                default: begin
                    r_nxt.bresp = ADCC_RESP_SLVERR;
                end
            endcase
        end

        // Read channel: one cycle to arready, data the next
        r_nxt.arready = 1'b0;
        if (s_axi_rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r_r.arready && !r_r.rvalid) begin
            r_nxt.arready = 1'b1;
        end
        if (r_r.arready) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp  = ADCC_RESP_OKAY;
            r_nxt.rdata  = 32'h0;
            case (ridx)
                ADCC_IDX_CTL0:    r_nxt.rdata[7:0] = r_r.ctl0;
                ADCC_IDX_CTL1:    r_nxt.rdata[7:0] = r_r.ctl1;
                ADCC_IDX_RES_HI: begin
                    r_nxt.rdata[7:0] = r_r.res[12:5];
                    hi_read = 1'b1;
                end
                ADCC_IDX_RES_LO:  r_nxt.rdata[7:0] = {r_r.lo_latch, 3'h0} | {7'h0, r_r.ovf};
                ADCC_IDX_IRQ_ST:  r_nxt.rdata[0] = r_r.irq_st;
                ADCC_IDX_IRQ_MSK: r_nxt.rdata[0] = r_r.irq_msk;
                // Calibration bytes: offset (two's complement) then two gain bytes
                ADCC_IDX_TRIM0:   r_nxt.rdata[23:0] = TRIM[23:0];
                ADCC_IDX_TRIM1:   r_nxt.rdata[23:0] = TRIM[47:24];
                ADCC_IDX_TRIM2:   r_nxt.rdata[23:0] = TRIM[71:48];
                default:          r_nxt.rresp = ADCC_RESP_SLVERR;
            endcase
        end
        if (hi_read) begin
            r_nxt.lo_latch = r_r.res[4:0];
        end

        // Conversion sequencer
        r_nxt.cnt = r_r.cnt + 13'h1;
        case (r_r.st)
            ADCC_OFF: begin
                r_nxt.cnt = 13'h0;
            end
            ADCC_PWRUP: begin
                if (r_r.cnt == PWRUP_LAST) begin
                    r_nxt.st  = ADCC_CONV;
                    r_nxt.cnt = 13'h0;
                end
            end
            ADCC_CONV: begin
                if ((!r_r.first_done && r_r.cnt == CONV_LAST) ||
                    (r_r.first_done && r_r.cnt == REPEAT_LAST)) begin
                    done             = 1'b1;
                    r_nxt.first_done = 1'b1;
                    r_nxt.cnt        = 13'h0;
                    r_nxt.ctl0[ADCC_GO_BIT] = 1'b0;
                    if (!r_r.ctl0[ADCC_REPEAT_BIT]) begin
                        r_nxt.st = ADCC_IDLE;
                    end
                end
            end
            ADCC_IDLE: begin
                if (r_r.cnt == IDLE_LAST) begin
                    r_nxt.st = ADCC_OFF;
                end
            end
            default: begin
                r_nxt.st = ADCC_OFF;
            end
        endcase
        if (done) begin
            r_nxt.res = conv_sample;
            r_nxt.ovf = conv_overflow;
        end
        if (wr_go) begin
            // Restart from the beginning, even mid-conversion
            r_nxt.ctl0[ADCC_GO_BIT] = 1'b1;
            r_nxt.first_done        = 1'b0;
            r_nxt.cnt               = 13'h0;
            r_nxt.st                = (r_r.st == ADCC_OFF) ? ADCC_PWRUP : ADCC_CONV;
            // Power-up under way keeps its progress; its last cycle hands over
            if (r_r.st == ADCC_PWRUP && r_r.cnt != PWRUP_LAST) begin
                r_nxt.st  = ADCC_PWRUP;
                r_nxt.cnt = r_r.cnt + 13'h1;
            end
        end

        // Set wins over a same-cycle clear
        if (done) begin
            r_nxt.irq_st = 1'b1;
        end

        r_nxt.sw     = (r_nxt.st == ADCC_CONV) ? sw_dec : '0;
        r_nxt.refl   = {r_nxt.ctl1[ADCC_REFHI_BIT], r_nxt.ctl0[ADCC_REFLO_BIT]};
        r_nxt.refout = r_nxt.ctl0[ADCC_REFOUT_BIT];
        r_nxt.pwr    = (r_nxt.st != ADCC_OFF);
        r_nxt.irq    = r_nxt.irq_st & r_nxt.irq_msk;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_r         <= '0;
            r_r.ctl0    <= ADCC_CTL0_RST;
            r_r.ctl1    <= ADCC_CTL1_RST;
            r_r.refl    <= ADCC_REF_2V0;
            r_r.st      <= ADCC_OFF;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign s_axi_awready     = r_r.awready;
    assign s_axi_wready      = r_r.wready;
    assign s_axi_bvalid      = r_r.bvalid;
    assign s_axi_bresp       = r_r.bresp;
    assign s_axi_arready     = r_r.arready;
    assign s_axi_rvalid      = r_r.rvalid;
    assign s_axi_rresp       = r_r.rresp;
    assign s_axi_rdata       = r_r.rdata;
    assign input_channel_sel = r_r.sw;
    assign ref_level         = r_r.refl;
    assign ref_out_buffer    = r_r.refout;
    assign conv_power_on     = r_r.pwr;
    assign conv_run          = r_r.ctl0[ADCC_GO_BIT];
    assign irq               = r_r.irq;

    a_go_clears_done: assert property (@(posedge aclk) disable iff (!aresetn)
        done && !wr_go |=> !conv_run) else $error("go bit stayed set after result");
    a_pwrup_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r_r.st == ADCC_PWRUP) && !wr_go |-> (r_r.st == ADCC_PWRUP)[*8])
        else $error("power-up shorter than expected");
    a_off_no_conv: assert property (@(posedge aclk) disable iff (!aresetn)
        (r_r.st == ADCC_OFF) |-> !done && !conv_power_on && input_channel_sel == '0)
        else $error("activity while powered down");
    a_ref_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_level == {r_r.ctl1[ADCC_REFHI_BIT], r_r.ctl0[ADCC_REFLO_BIT]})
        else $error("reference level mismatch");
    a_refout_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_out_buffer == r_r.ctl0[ADCC_REFOUT_BIT]) else $error("reference buffer mismatch");
    a_reserved_open: assert property (@(posedge aclk) disable iff (!aresetn)
        r_r.ctl0[3] |=> ##1 (input_channel_sel == '0 || !$past(r_r.ctl0[3])))
        else $error("switch closed on reserved code");
    a_irq_on_done: assert property (@(posedge aclk) disable iff (!aresetn)
        done |=> r_r.irq_st) else $error("result did not flag interrupt");
    a_repeat_gap: assert property (@(posedge aclk) disable iff (!aresetn)
        done && r_r.ctl0[ADCC_REPEAT_BIT] && !wr_go |-> ##1 !done [*8])
        else $error("results too close");
    a_latch_hi: assert property (@(posedge aclk) disable iff (!aresetn)
        hi_read |=> r_r.lo_latch == $past(r_r.res[4:0])) else $error("low bits not latched");
    a_start_run: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> conv_run && r_r.cnt <= PWRUP_LAST) else $error("go write did not start");
endmodule : adcc_top
`default_nettype wire

/* File: test/adcc_core_model.sv */
// Behavioural analog core: a sample that names the closed input switch.
// Assumes one-hot switch enables and a sample taken at conversion end.
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model (
    input  wire logic        aclk,
    input  wire logic [7:0]  sw_en,
    output logic      [12:0] sample,
    output logic             ovf
);
    logic [12:0] samp_r = 13'h0000;
    logic        ovf_r  = 1'b0;
    assign sample = samp_r;
    assign ovf    = ovf_r;
    // Holds the last value once the switches open, as the filter would
    always @(posedge aclk) begin
        if (sw_en != 8'h00) begin
            ovf_r <= 1'b0;
            for (int i = 0; i < 8; i++)
                if (sw_en[i]) samp_r <= {sw_en, 5'(i)};
        end
    end
endmodule : adcc_core_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench: AXI4-Lite register tasks and conversion sequences.
// Assumes a shortened conversion count and the behavioural core model.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import adcc_pkg::*;
    localparam int CONV = 300; // Short count keeps the run brief
    localparam int PWR  = 40;
    logic [ADCC_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]            wdata, rdata, got;
    logic [1:0]             bresp, rresp, resp, ref_level;
    logic [12:0]            sample;
    logic [7:0]             sel;
    logic                   aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                   arvalid, arready, rvalid, rready, ovf, ref_out, pwr_on, run, irq;
    int                     bad_count, comparisons, cyc, t0;

    adcc_top #(.CONV_CYC(CONV), .TRIM(72'hf61234_f61234_f61234)) u_adcc_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .conv_sample(sample), .conv_overflow(ovf), .input_channel_sel(sel),
        .ref_level(ref_level), .ref_out_buffer(ref_out), .conv_power_on(pwr_on),
        .conv_run(run), .irq(irq));
    adcc_core_model u_adcc_core_model (.aclk(aclk), .sw_en(sel), .sample(sample), .ovf(ovf));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        comparisons++;
        if (act !== exp) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, act);
        end
    endtask : chk
    task automatic chk_win(input int lo, input int hi, input int act);
        comparisons++;
        if (act < lo || act > hi) begin
            bad_count++;
            $display("wrong value at %0t: expected %h..%h got %h", $time, lo, hi, act);
        end
    endtask : chk_win
    // Address and data go up together; the slave takes both at once
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] idx);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        got  = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic wait_irq;
        do @(posedge aclk); while (irq !== 1'b1);
    endtask : wait_irq
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        give_verdict();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, cyc, bad_count, comparisons} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADCC_IDX_CTL0); chk(32'h00, got);
        rd(ADCC_IDX_CTL1); chk(32'h80, got);
        chk(32'h2, {30'h0, ref_level});
        rd(12'hf79); chk({30'h0, ADCC_RESP_SLVERR}, {30'h0, resp});
        wr(12'hf79, 8'h00); chk({30'h0, ADCC_RESP_SLVERR}, {30'h0, resp});
        wr(ADCC_IDX_RES_HI, 8'hff); chk({30'h0, ADCC_RESP_OKAY}, {30'h0, resp});
        rd(ADCC_IDX_TRIM0); chk(32'h00f61234, got);
        for (int i = 0; i < 3; i++) begin
            wr(ADCC_IDX_CTL1, {i[1], 7'h00});
            wr(ADCC_IDX_CTL0, {1'b0, i[0], i[0], 5'h00});
            chk({30'h0, 2'(i)}, {30'h0, ref_level});
            chk({31'h0, i[0]}, {31'h0, ref_out});
        end
        // First conversion starts from power-down
        wr(ADCC_IDX_IRQ_MSK, 8'h01);
        wr(ADCC_IDX_CTL0, 8'h83); t0 = cyc;
        repeat (60) @(posedge aclk);
        chk(32'h08, {24'h0, sel});
        rd(ADCC_IDX_CTL0); chk(32'h83, got);
        wait_irq(); chk_win(PWR + CONV - 4, PWR + CONV + 4, cyc - t0);
        rd(ADCC_IDX_CTL0); chk(32'h03, got);
        rd(ADCC_IDX_RES_HI); chk(32'h08, got);
        rd(ADCC_IDX_RES_LO); chk(32'h18, got & 32'hf9);
        wr(ADCC_IDX_IRQ_ST, 8'h01); chk(32'h0, {31'h0, irq});
        // Restart from idle; a zero write must not stop the run
        wr(ADCC_IDX_CTL0, 8'h86);
        repeat (100) @(posedge aclk);
        wr(ADCC_IDX_CTL0, 8'h06); chk(32'h1, {31'h0, run});
        wr(ADCC_IDX_CTL0, 8'h86); t0 = cyc;
        wait_irq(); chk_win(CONV - 4, CONV + 4, cyc - t0);
        repeat (150) @(posedge aclk);
        chk(32'h1, {31'h0, pwr_on});
        repeat (15) @(posedge aclk);
        chk(32'h0, {31'h0, pwr_on});
        rd(ADCC_IDX_RES_HI); chk(32'h40, got);
        wr(ADCC_IDX_IRQ_ST, 8'h01);
        // Reserved code with the interrupt masked
        wr(ADCC_IDX_IRQ_MSK, 8'h00);
        wr(ADCC_IDX_CTL0, 8'h88);
        repeat (60) @(posedge aclk);
        chk(32'h0, {24'h0, sel});
        repeat (400) @(posedge aclk);
        chk(32'h0, {31'h0, irq});
        rd(ADCC_IDX_IRQ_ST); chk(32'h1, got & 32'h1);
        wr(ADCC_IDX_IRQ_MSK, 8'h01); chk(32'h1, {31'h0, irq});
        wr(ADCC_IDX_IRQ_ST, 8'h01); chk(32'h0, {31'h0, irq});
        // Repeat mode: go clears once, results keep coming
        wr(ADCC_IDX_CTL0, 8'h95);
        wait_irq(); t0 = cyc;
        wr(ADCC_IDX_IRQ_ST, 8'h01);
        rd(ADCC_IDX_CTL0); chk(32'h15, got);
        wait_irq(); chk_win(252, 260, cyc - t0);
        rd(ADCC_IDX_RES_HI); chk(32'h20, got);
        wr(ADCC_IDX_CTL0, 8'h05);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
